// ===== core/tcd_dma.sv
// ten-channel dma engine with apb register file and a single-master memory port
// assumes mem_ack is a one-cycle pulse per request and periph_req comes from pclk logic
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps

module tcd_dma (
   input  wire logic        pclk,         // 10 MHz clock
   input  wire logic        presetn,      // async reset, active low
   input  wire logic [7:0]  paddr,        // apb byte address
   input  wire logic        psel,         // apb select
   input  wire logic        penable,      // apb access phase
   input  wire logic        pwrite,       // apb direction
   input  wire logic [31:0] pwdata,       // apb write data
   output logic      [31:0] prdata,       // apb read data
   output logic             pready,       // apb ready
   output logic             pslverr,      // apb error on unmapped address
   input  wire logic [tcd_pkg::TCD_NCH-1:0] periph_req, // peripheral request pulses
   output logic             mem_req,      // memory request, held until ack
   output logic             mem_we,       // 1 write, 0 read
   output logic             mem_size16,   // 16-bit unit
   output logic      [31:0] mem_addr,     // byte address
   output logic      [15:0] mem_wdata,    // write data
   input  wire logic [15:0] mem_rdata,    // read data, valid with ack
   input  wire logic        mem_ack,      // one-cycle answer
   output logic             dma_irq       // grouped underflow interrupt
);
   import tcd_pkg::*;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // next address for one unit; ring wraps inside 32 units
   function automatic logic [15:0] tcd_step(input logic [15:0] a, input tcd_amode_t m,
                                            input logic s16);
      logic [15:0] inc;
      inc = a + (s16 ? 16'h0002 : 16'h0001);
      if (m == AM_INC) begin
         return inc;
      end else if (m == AM_RING) begin
         return s16 ? {a[15:6], inc[5:0]} : {a[15:5], inc[4:0]};
      end
      return a;
   endfunction
   function automatic logic [3:0] tcd_first(input logic [TCD_NCH-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = TCD_NCH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   typedef enum logic [1:0] {S_IDLE, S_RD, S_GAP, S_WR} tcd_state_t;
   tcd_ctrl_t         ctrl_ff [TCD_NCH];
   tcd_ctrl_t         nxt_ctrl [TCD_NCH];
   logic [15:0]       src_ff [TCD_NCH];
   logic [15:0]       nxt_src [TCD_NCH];
   logic [15:0]       dst_ff [TCD_NCH];
   logic [15:0]       nxt_dst [TCD_NCH];
   logic [7:0]        cnt_ff [TCD_NCH];
   logic [7:0]        nxt_cnt [TCD_NCH];
   logic [TCD_NCH-1:0] uf_ff, nxt_uf, pend_ff, nxt_pend;
   logic [TCD_NCH-1:0] en_vec, elig, fire, xhit, uhit, done_vec, uf_ev, swt;
   tcd_state_t        st_ff, nxt_st;
   logic [3:0]        ch_ff, nxt_ch;
   logic [15:0]       data_ff, nxt_data;
   logic              mreq_ff, nxt_mreq, mwe_ff, nxt_mwe, ms16_ff, nxt_ms16;
   logic [15:0]       maddr_ff, nxt_maddr;
   logic [31:0]       prdata_ff, nxt_prdata;
   logic              pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff;
   logic              wr_en, xfer_done;
   logic [3:0]        a_ch;
   logic [1:0]        a_reg;
   logic              a_chan;

   // -----------------------------------------------------------------
   // request sources
   // -----------------------------------------------------------------
   assign a_ch      = paddr[7:4];
   assign a_reg     = paddr[3:2];
   assign a_chan    = (a_ch < 4'(TCD_NCH));
   assign wr_en     = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   assign xfer_done = (st_ff == S_WR) & mem_ack;
   assign swt       = (wr_en && paddr == TCD_OFF_SWT) ? pwdata[TCD_NCH-1:0] : '0;

   // cascade wiring per target channel
   for (genvar t = 0; t < TCD_NCH; t++) begin : g_ch
      logic x_fix, u_fix;
      assign en_vec[t]   = ctrl_ff[t].en;
      assign done_vec[t] = xfer_done && (ch_ff == 4'(t));
      assign uf_ev[t]    = done_vec[t] && (cnt_ff[t] == 8'h00);
      if (TCD_XSRC[t] != TCD_NONE) begin : g_x
         assign x_fix = done_vec[TCD_XSRC[t]];
      end else begin : g_nx
         assign x_fix = 1'b0;
      end
      if (TCD_USRC[t] != TCD_NONE) begin : g_u
         assign u_fix = uf_ev[TCD_USRC[t]];
      end else begin : g_nu
         assign u_fix = 1'b0;
      end
      // channel 9 picks a target in 1..9, channel 1 one in 0..9
      assign xhit[t] = x_fix | ((t != 0) && done_vec[9] && ctrl_ff[9].tgt == 4'(t));
      assign uhit[t] = u_fix | (uf_ev[1] && ctrl_ff[1].tgt == 4'(t));
      assign fire[t] = swt[t]
                     | (ctrl_ff[t].trig == TRG_PERIPH && periph_req[t])
                     | (ctrl_ff[t].trig == TRG_CASC_X && xhit[t])
                     | (ctrl_ff[t].trig == TRG_CASC_U && uhit[t]);
   end

   assign elig = pend_ff & en_vec;

   // -----------------------------------------------------------------
   // transfer engine
   // -----------------------------------------------------------------
   // a gap state drops mem_req between read and write so each ack is unambiguous
   always_comb begin
      nxt_st    = st_ff;
      nxt_ch    = ch_ff;
      nxt_data  = data_ff;
      nxt_mreq  = mreq_ff;
      nxt_mwe   = mwe_ff;
      nxt_ms16  = ms16_ff;
      nxt_maddr = maddr_ff;
      unique case (st_ff)
         S_IDLE: begin
            if (|elig) begin
               nxt_ch    = tcd_first(elig);
               nxt_ms16  = ctrl_ff[nxt_ch].size16;
               nxt_maddr = src_ff[nxt_ch];
               nxt_mwe   = 1'b0;
               nxt_mreq  = 1'b1;
               nxt_st    = S_RD;
            end
         end
         S_RD: begin
            if (mem_ack) begin
               nxt_data = ms16_ff ? mem_rdata : {8'h00, mem_rdata[7:0]};
               nxt_mreq = 1'b0;
               nxt_st   = S_GAP;
            end
         end
         S_GAP: begin
            nxt_maddr = dst_ff[ch_ff];
            nxt_mwe   = 1'b1;
            nxt_mreq  = 1'b1;
            nxt_st    = S_WR;
         end
         S_WR: begin
            if (mem_ack) begin
               nxt_mreq = 1'b0;
               nxt_mwe  = 1'b0;
               nxt_st   = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff    <= S_IDLE;
         ch_ff    <= 4'h0;
         data_ff  <= 16'h0000;
         mreq_ff  <= 1'b0;
         mwe_ff   <= 1'b0;
         ms16_ff  <= 1'b0;
         maddr_ff <= TCD_ADDR_RST;
      end else begin
         st_ff    <= nxt_st;
         ch_ff    <= nxt_ch;
         data_ff  <= nxt_data;
         mreq_ff  <= nxt_mreq;
         mwe_ff   <= nxt_mwe;
         ms16_ff  <= nxt_ms16;
         maddr_ff <= nxt_maddr;
      end
   end

   // -----------------------------------------------------------------
   // channel registers and flags
   // -----------------------------------------------------------------
   // engine updates come first; software writes override; underflow disable last
   always_comb begin
      for (int i = 0; i < TCD_NCH; i++) begin
         nxt_ctrl[i] = ctrl_ff[i];
         nxt_src[i]  = src_ff[i];
         nxt_dst[i]  = dst_ff[i];
         nxt_cnt[i]  = cnt_ff[i];
      end
      if (xfer_done) begin
         nxt_src[ch_ff] = tcd_step(src_ff[ch_ff], ctrl_ff[ch_ff].smode, ms16_ff);
         nxt_dst[ch_ff] = tcd_step(dst_ff[ch_ff], ctrl_ff[ch_ff].dmode, ms16_ff);
         nxt_cnt[ch_ff] = cnt_ff[ch_ff] - 8'h01;
      end
      if (wr_en && a_chan) begin
         unique case (a_reg)
            TCD_REG_CTRL: nxt_ctrl[a_ch] = tcd_ctrl_t'(pwdata[11:0]);
            TCD_REG_SRC:  nxt_src[a_ch]  = pwdata[15:0];
            TCD_REG_DST:  nxt_dst[a_ch]  = pwdata[15:0];
            TCD_REG_CNT:  nxt_cnt[a_ch]  = pwdata[7:0];
         endcase
      end
      // only a request in the cycle its own transfer completes stays pending, earlier ones merge; disabled channels drop theirs
      nxt_pend = (pend_ff & ~done_vec) | fire;
      for (int i = 0; i < TCD_NCH; i++) begin
         if (uf_ev[i]) begin
            nxt_ctrl[i].en = 1'b0;
         end
         nxt_pend[i] = nxt_pend[i] & nxt_ctrl[i].en;
      end
      // set wins over the write-one clear
      nxt_uf = uf_ff;
      if (wr_en && paddr == TCD_OFF_UF) begin
         nxt_uf = uf_ff & ~pwdata[TCD_NCH-1:0];
      end
      nxt_uf = nxt_uf | uf_ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < TCD_NCH; i++) begin
            ctrl_ff[i] <= TCD_CTRL_RST;
            src_ff[i]  <= TCD_ADDR_RST;
            dst_ff[i]  <= TCD_ADDR_RST;
            cnt_ff[i]  <= TCD_CNT_RST;
         end
         uf_ff   <= '0;
         pend_ff <= '0;
         irq_ff  <= 1'b0;
      end else begin
         for (int i = 0; i < TCD_NCH; i++) begin
            ctrl_ff[i] <= nxt_ctrl[i];
            src_ff[i]  <= nxt_src[i];
            dst_ff[i]  <= nxt_dst[i];
            cnt_ff[i]  <= nxt_cnt[i];
         end
         uf_ff   <= nxt_uf;
         pend_ff <= nxt_pend;
         irq_ff  <= |nxt_uf;
      end
   end

   // -----------------------------------------------------------------
   // apb answer: one access cycle, data registered in the setup cycle
   // -----------------------------------------------------------------
   always_comb begin
      nxt_pready  = psel & ~penable;
      nxt_pslverr = 1'b0;
      nxt_prdata  = 32'h0000_0000;
      if (psel && !penable) begin
         if (a_chan) begin
            unique case (a_reg)
               TCD_REG_CTRL: nxt_prdata = {20'h00000, ctrl_ff[a_ch]};
               TCD_REG_SRC:  nxt_prdata = {TCD_WIN_HI, src_ff[a_ch]};
               TCD_REG_DST:  nxt_prdata = {TCD_WIN_HI, dst_ff[a_ch]};
               TCD_REG_CNT:  nxt_prdata = {24'h000000, cnt_ff[a_ch]};
            endcase
         end else if (paddr == TCD_OFF_UF) begin
            nxt_prdata = {22'h000000, uf_ff};
         end else if (paddr == TCD_OFF_STAT) begin
            nxt_prdata = {15'h0000, st_ff != S_IDLE, 6'h00, pend_ff};
         end else if (paddr != TCD_OFF_SWT) begin
            nxt_pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign mem_req    = mreq_ff;
   assign mem_we     = mwe_ff;
   assign mem_size16 = ms16_ff;
   assign mem_addr   = {TCD_WIN_HI, maddr_ff};
   assign mem_wdata  = data_ff;
   assign dma_irq    = irq_ff;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] cur_cnt;
   assign cur_cnt = cnt_ff[ch_ff];

   bus_release_a: assert property (xfer_done |=> !mem_req && st_ff == S_IDLE)
      else $error("bus not released after write");
   read_first_a: assert property ((st_ff == S_RD && mem_req) |-> !mem_we)
      else $error("first access of a transfer is not a read");
   addr_window_a: assert property (mem_req |-> mem_addr[31:16] == 16'h0080)
      else $error("address outside the window");
   grant_prio_a: assert property ((st_ff == S_IDLE && |elig)
      |=> ($past(elig) & ((10'h001 << ch_ff) - 10'h001)) == 10'h000)
      else $error("higher priority channel skipped");
   count_dec_a: assert property ((xfer_done && !wr_en) |=> cur_cnt == $past(cur_cnt) - 8'h01)
      else $error("count not decremented");
   uf_irq_a: assert property (|uf_ev |=> dma_irq && !ctrl_ff[ch_ff].en)
      else $error("underflow did not raise interrupt or stop channel");
   casc_ring_a: assert property ((done_vec[0] && ctrl_ff[1].en
      && ctrl_ff[1].trig == TRG_CASC_X && !uf_ev[1]) |=> pend_ff[1])
      else $error("cascade 0 to 1 missing");
   casc_uf_a: assert property ((uf_ev[0] && ctrl_ff[5].en
      && ctrl_ff[5].trig == TRG_CASC_U) |=> pend_ff[5])
      else $error("underflow cascade 0 to 5 missing");
   casc_nine_a: assert property ((done_vec[9] && ctrl_ff[9].tgt == 4'h6
      && ctrl_ff[6].en && ctrl_ff[6].trig == TRG_CASC_X) |=> pend_ff[6])
      else $error("cascade from 9 missing");
   full_xfer_c: cover property (st_ff == S_IDLE ##1 st_ff == S_RD ##[1:8] xfer_done);
   underflow_c: cover property (|uf_ev);
   two_pend_c:  cover property ($countones(elig) > 1);
endmodule // tcd_dma

// ===== core/tcd_pkg.sv
// package for the ten-channel dma controller: field layouts, offsets, reset values
// assumes a 32-bit apb slave port and a 16-bit internal memory bus on one clock
package tcd_pkg;

   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int TCD_NCH = 10;                       // number of channels
   localparam logic [15:0] TCD_WIN_HI = 16'h0080;     // upper half of every bus address
   localparam int TCD_RING_LEN = 32;                  // entries in a ring buffer

   // -----------------------------------------------------------------
   // register map: channel n sits at n*16, word index in paddr[3:2]
   // -----------------------------------------------------------------
   localparam logic [1:0] TCD_REG_CTRL = 2'h0;
   localparam logic [1:0] TCD_REG_SRC  = 2'h1;
   localparam logic [1:0] TCD_REG_DST  = 2'h2;
   localparam logic [1:0] TCD_REG_CNT  = 2'h3;
   localparam logic [7:0] TCD_OFF_UF   = 8'ha0;       // underflow flags, write 1 to clear
   localparam logic [7:0] TCD_OFF_SWT  = 8'ha4;       // software trigger, write 1 to fire
   localparam logic [7:0] TCD_OFF_STAT = 8'ha8;       // pending bits and engine busy

   // -----------------------------------------------------------------
   // channel control word
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {AM_FIXED, AM_INC, AM_RING, AM_RSVD} tcd_amode_t;
   typedef enum logic [1:0] {TRG_SW, TRG_PERIPH, TRG_CASC_X, TRG_CASC_U} tcd_trig_t;

   typedef struct packed {
      logic [3:0] tgt;                                 // [11:8] cascade target (ch1, ch9)
      tcd_trig_t  trig;                                // [7:6]
      tcd_amode_t dmode;                               // [5:4]
      tcd_amode_t smode;                               // [3:2]
      logic       size16;                              // [1]
      logic       en;                                  // [0]
   } tcd_ctrl_t;

   localparam tcd_ctrl_t   TCD_CTRL_RST = '{tgt: 4'h0, trig: TRG_SW, dmode: AM_FIXED,
                                            smode: AM_FIXED, size16: 1'b0, en: 1'b0};
   localparam logic [15:0] TCD_ADDR_RST = 16'h0000;
   localparam logic [7:0]  TCD_CNT_RST  = 8'h00;

   // fixed cascade sources per target channel; 15 means none
   localparam logic [3:0] TCD_XSRC [TCD_NCH] = '{4'h2, 4'h0, 4'h1, 4'hf, 4'h3,
                                                  4'h7, 4'h5, 4'h6, 4'hf, 4'h8};
   localparam logic [3:0] TCD_USRC [TCD_NCH] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf,
                                                  4'h0, 4'hf, 4'hf, 4'h3, 4'hf};
   localparam logic [3:0] TCD_NONE = 4'hf;

endpackage

// ===== testbench/tcd_mem_model.sv
// memory-side model for the dma port: bus-reachable ram
// assumes one request at a time, each answered by a one-cycle ack
`timescale 1ns/10ps
module tcd_mem_model (
   input  wire logic        pclk,        // clock
   input  wire logic        mem_req,     // request level
   input  wire logic        mem_we,      // 1 write
   input  wire logic        mem_size16,  // 16-bit unit
   input  wire logic [31:0] mem_addr,    // byte address
   input  wire logic [15:0] mem_wdata,   // write data
   input  wire logic [3:0]  lat,         // idle cycles before ack
   output logic      [15:0] mem_rdata,   // read data
   output logic             mem_ack      // one-cycle answer
);
   logic [7:0]  mem [65536];
   logic [15:0] wlog [1024];
   logic [3:0]  cnt;
   int          nwr;
   logic        bad;
   logic        rd_done;
   // pattern fill so a missed write shows up
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8) ^ 8'h5a);
      {mem_ack, cnt, nwr, bad, rd_done, mem_rdata} = '0;
   end
   // answer after lat cycles; data toggles when idle so stale values never match
   always @(posedge pclk) begin
      if (mem_req && !mem_ack && cnt >= lat) begin
         mem_ack <= 1'b1;
         cnt     <= 4'h0;
         if (mem_addr[31:16] != 16'h0080) bad <= 1'b1;
         if (mem_we) begin
            if (!rd_done) bad <= 1'b1;
            mem[mem_addr[15:0]] <= mem_wdata[7:0];
            if (mem_size16) mem[mem_addr[15:0] + 16'h1] <= mem_wdata[15:8];
            wlog[nwr[9:0]] <= mem_addr[15:0];
            nwr <= nwr + 1;
            rd_done <= 1'b0;
         end else begin
            mem_rdata <= {mem_size16 ? mem[mem_addr[15:0] + 16'h1] : ~mem[mem_addr[15:0]],
                          mem[mem_addr[15:0]]};
            rd_done <= 1'b1;
         end
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) cnt <= cnt + 4'h1;
      end
   end
endmodule // tcd_mem_model

// ===== testbench/tb_ten_channel_dma_controller.sv
// self-checking bench for the ten-channel dma engine
// assumes the memory model answers every request on the memory port
`timescale 1ns/10ps
module tb_ten_channel_dma_controller;
   import tcd_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        mem_req, mem_we, mem_size16, mem_ack, dma_irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, mem_addr, rd;
   logic [15:0] mem_wdata, mem_rdata;
   logic [9:0]  periph_req;
   logic [3:0]  lat;
   int          num_errors, checks, n0;
   // -----------------------------------------------------------------
   // instances and clock
   // -----------------------------------------------------------------
   tcd_dma tcd_dma_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .mem_req(mem_req),
      .mem_we(mem_we), .mem_size16(mem_size16), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dma_irq(dma_irq));
   tcd_mem_model tcd_mem_model_inst (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
      .mem_size16(mem_size16), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   // 10 MHz
   always #50 pclk = ~pclk;
   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] mb(input logic [15:0] a);
      return tcd_mem_model_inst.mem[a];
   endfunction
   // one apb transfer, entered just after a rising edge, one idle cycle after
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // poll status until nothing pending and engine idle
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'ha8, 32'h0);
         n++;
      end while (rd[16:0] !== 17'h0 && n < 100);
      if (n >= 100) begin
         num_errors++;
         final_report();
      end
   endtask
   task automatic setch(input int c, input logic [31:0] ctl, input logic [15:0] s,
                        input logic [15:0] d, input logic [7:0] cnt);
      apb(1'b1, 8'(c * 16 + 4), {16'h0, s});
      apb(1'b1, 8'(c * 16 + 8), {16'h0, d});
      apb(1'b1, 8'(c * 16 + 12), {24'h0, cnt});
      apb(1'b1, 8'(c * 16), ctl);
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      apb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'hb0, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      check(dma_irq, 1'b0);
   endtask
   // 16-bit inc/inc, count 3 gives four units, then the channel refuses
   task automatic t_burst16();
      n0 = tcd_mem_model_inst.nwr;
      setch(0, 32'h17, 16'h0100, 16'h0200, 8'h03);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'ha4, 32'h1);
         wait_idle();
      end
      for (int i = 0; i < 8; i++) check(mb(16'h0200 + i), mb(16'h0100 + i));
      check(tcd_mem_model_inst.nwr - n0, 4);
      check(dma_irq, 1'b1);
      apb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h16);
      apb(1'b1, 8'ha4, 32'h1);
      wait_idle();
      check(tcd_mem_model_inst.nwr - n0, 4);
      apb(1'b1, 8'ha0, 32'h1);
      check(dma_irq, 1'b0);
   endtask
   // peripheral start on ch4, full 256-unit count, slow memory
   task automatic t_periph256();
      lat <= 4'h2;
      n0 = tcd_mem_model_inst.nwr;
      setch(4, 32'h41, 16'h0600, 16'h0700, 8'hff);
      for (int i = 0; i < 256; i++) begin
         periph_req <= 10'h010;
         @(posedge pclk);
         periph_req <= 10'h000;
         wait_idle();
         if (i == 254) check(dma_irq, 1'b0);
      end
      check(tcd_mem_model_inst.nwr - n0, 256);
      check(dma_irq, 1'b1);
      check(mb(16'h0700), mb(16'h0600));
      apb(1'b1, 8'ha0, 32'h3ff);
   endtask
   // ch2 and ch5 fired together: lower number served first
   task automatic t_prio();
      n0 = tcd_mem_model_inst.nwr;
      setch(5, 32'h01, 16'h0300, 16'h0400, 8'h05);
      setch(2, 32'h01, 16'h0310, 16'h0410, 8'h05);
      apb(1'b1, 8'ha4, 32'h24);
      wait_idle();
      check(tcd_mem_model_inst.wlog[n0], 16'h0410);
      check(tcd_mem_model_inst.wlog[n0 + 1], 16'h0400);
   endtask
   // ch3 underflows: per-transfer cascade to ch4, underflow cascade to ch8
   task automatic t_cascade();
      lat <= 4'h0;
      n0 = tcd_mem_model_inst.nwr;
      setch(3, 32'h01, 16'h0320, 16'h0420, 8'h00);
      setch(4, 32'h81, 16'h0330, 16'h0430, 8'h05);
      setch(8, 32'hc1, 16'h0340, 16'h0440, 8'h05);
      setch(6, 32'h81, 16'h0360, 16'h0460, 8'h05);
      setch(9, 32'h601, 16'h0350, 16'h0450, 8'h05);
      apb(1'b1, 8'ha4, 32'h8);
      wait_idle();
      check(tcd_mem_model_inst.wlog[n0], 16'h0420);
      check(tcd_mem_model_inst.wlog[n0 + 1], 16'h0430);
      check(tcd_mem_model_inst.wlog[n0 + 2], 16'h0440);
      check(tcd_mem_model_inst.nwr - n0, 3);
      apb(1'b1, 8'ha4, 32'h200);
      wait_idle();
      check(tcd_mem_model_inst.wlog[n0 + 3], 16'h0450);
      check(tcd_mem_model_inst.wlog[n0 + 4], 16'h0460);
      apb(1'b1, 8'ha0, 32'h3ff);
   endtask
   // 8-bit ring source wraps within its 32-byte block
   task automatic t_ring();
      setch(7, 32'h19, 16'h03ff, 16'h0500, 8'h01);
      apb(1'b1, 8'ha4, 32'h80);
      wait_idle();
      apb(1'b1, 8'ha4, 32'h80);
      wait_idle();
      check(mb(16'h0500), mb(16'h03ff));
      check(mb(16'h0501), mb(16'h03e0));
      check(tcd_mem_model_inst.bad, 1'b0);
   endtask
   // ch0 count 0: per-transfer cascade to ch1, underflow cascade to ch5
   task automatic t_casc0();
      n0 = tcd_mem_model_inst.nwr;
      setch(1, 32'h81, 16'h0370, 16'h0470, 8'h05);
      setch(5, 32'hc1, 16'h0380, 16'h0480, 8'h05);
      setch(0, 32'h01, 16'h0390, 16'h0490, 8'h00);
      apb(1'b1, 8'ha4, 32'h1);
      wait_idle();
      check(tcd_mem_model_inst.wlog[n0], 16'h0490);
      check(tcd_mem_model_inst.wlog[n0 + 1], 16'h0470);
      check(tcd_mem_model_inst.wlog[n0 + 2], 16'h0480);
   endtask
   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, periph_req, lat} = '0;
      num_errors = 0;
      checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_burst16();
      t_periph256();
      t_prio();
      t_cascade();
      t_ring();
      t_casc0();
      final_report();
   end
   // cuts a hang short
   initial begin
      #9000000;
      num_errors++;
      final_report();
   end
endmodule // tb_ten_channel_dma_controller
